// file: src/plcwx_pkg.sv
// Shared constants and types for the word exchange, digit shift and decode datapath
package plcwx_pkg;

  // Instruction select codes
  typedef enum logic [1:0] {
    CHANNEL_EXCHANGE_OP       = 2'h0,
    DIGIT_SHIFT_LEFT_OP       = 2'h1,
    DIGIT_SHIFT_RIGHT_OP      = 2'h2,
    FOUR_TO_SIXTEEN_DECODE_OP = 2'h3
  } plcwx_op_t;

  // Sequencer states, Gray along idle-resolve-check-read-wait-execute
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_IND_A = 4'h1,
    ST_IND_B = 4'h3,
    ST_CHECK = 4'h2,
    ST_RD    = 4'h6,
    ST_WAIT  = 4'h7,
    ST_EXE   = 4'h5,
    ST_DEC   = 4'h4,
    ST_WR2   = 4'hC,
    ST_FIN   = 4'hD,
    ST_GOT_B = 4'hE,
    ST_GOT_A = 4'hF
  } plcwx_state_t;

  // Operand area codes, upper three bits of a memory address
  localparam logic [2:0] AREA_IO            = 3'h0;
  localparam logic [2:0] AREA_LINK          = 3'h1;
  localparam logic [2:0] AREA_HOLDING       = 3'h2;
  localparam logic [2:0] AREA_TIMER_COUNTER = 3'h3;
  localparam logic [2:0] AREA_DATA_MEMORY   = 3'h4;

  // Highest channel number of each area
  localparam logic [9:0] IO_MAX            = 10'h03C;
  localparam logic [9:0] IO_SRC_MAX        = 10'h03F;
  localparam logic [9:0] LINK_MAX          = 10'h01F;
  localparam logic [9:0] HOLDING_MAX       = 10'h01F;
  localparam logic [9:0] TIMER_COUNTER_MAX = 10'h07F;
  localparam logic [9:0] DATA_MEMORY_MAX   = 10'h1FF;
  localparam logic [13:0] IND_LIMIT        = 14'h0200;

  // Designation constant fields
  localparam logic [3:0] DESIG_FIELD_MAX = 4'h3;

  // Register offsets on the plain register port
  localparam logic [1:0] REG_CTRL       = 2'h0;
  localparam logic [1:0] REG_STATUS     = 2'h1;
  localparam logic [1:0] REG_EXEC_COUNT = 2'h2;
  localparam logic [1:0] REG_ERR_COUNT  = 2'h3;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         STAT_ERR_BIT   = 0;
  localparam int         STAT_BUSY_BIT  = 1;
  localparam logic       CTRL_EN_RST    = 1'b1;

endpackage

// file: src/plcwx_core.sv
// Datapath and sequencer for channel exchange, digit shifts and 4-to-16 decode
//
// Functional notes
// - Condition bit zero: no operation, operands kept
// - Executes again on every start while condition set
// - Exchange swaps both full 16-bit channels
// - Third operand ignored for exchange and shifts
// - Indirect references only through data memory 0-511
// - Non-BCD or 512+ indirect word: error, skip
// - Operand outside area range: error, no execution
// - Shift left moves digits up, zero enters bottom
// - Left shift walks start channel up to end
// - Shift right moves every digit down one place
// - Right shift walks end channel down to start
// - Shifts need start not above end, same area
// - Decoder sets only matching bit of sixteen
// - Count field selects one to four decoded digits
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps

module plcwx_core
  import plcwx_pkg::*;
(
  input  wire logic        clk_i,        // 20 MHz scan clock
  input  wire logic        resetn_i,     // Asynchronous reset, active low
  input  wire logic        start_i,      // Instruction request pulse
  input  wire logic        cond_i,       // Logic result condition bit
  input  wire logic [1:0]  opcode_i,     // Instruction select
  input  wire logic [2:0]  a_area_i,     // First operand area
  input  wire logic [9:0]  a_num_i,      // First operand channel
  input  wire logic        a_ind_i,      // First operand is indirect
  input  wire logic [2:0]  b_area_i,     // Second operand area
  input  wire logic [9:0]  b_num_i,      // Second operand channel
  input  wire logic        b_ind_i,      // Second operand is indirect
  input  wire logic [15:0] k_i,          // Third operand word
  input  wire logic [15:0] mem_rdata_i,  // Read data, cycle after mem_rd_o
  input  wire logic [1:0]  reg_addr_i,   // Register offset
  input  wire logic [15:0] reg_wdata_i,  // Register write data
  input  wire logic        reg_wr_i,     // Register write strobe
  input  wire logic        reg_rd_i,     // Register read strobe
  output logic             busy_o,       // Instruction in progress
  output logic             done_o,       // Instruction finished pulse
  output logic             err_flag_o,   // Error relay pulse with done
  output logic             mem_rd_o,     // Memory read strobe
  output logic             mem_wr_o,     // Memory write strobe
  output logic [12:0]      mem_addr_o,   // Area and channel address
  output logic [15:0]      mem_wdata_o,  // Memory write data
  output logic [15:0]      reg_rdata_o   // Register read data
);

  // Whole module state
  typedef struct packed {
    plcwx_state_t st;          // Sequencer state
    plcwx_state_t ret;         // State after a read wait
    plcwx_op_t    op;          // Latched instruction
    logic [2:0]   a_area;      // First operand area
    logic [9:0]   a_num;       // First operand channel
    logic         a_ind;       // First operand indirect
    logic [2:0]   b_area;      // Second operand area
    logic [9:0]   b_num;       // Second operand channel
    logic         b_ind;       // Second operand indirect
    logic [15:0]  k;           // Designation constant
    logic [9:0]   cur;         // Channel or digit iterator
    logic [3:0]   carry;       // Digit moving between channels
    logic [15:0]  tmp;         // Held word
    logic         fail;        // Error seen during this instruction
    logic         busy;        // Busy output
    logic         done;        // Done output
    logic         err;         // Error relay output
    logic         mem_rd;      // Read strobe output
    logic         mem_wr;      // Write strobe output
    logic [12:0]  mem_addr;    // Address output
    logic [15:0]  mem_wdata;   // Write data output
    logic         en;          // Execution enable
    logic         err_sticky;  // Sticky error status
    logic [15:0]  exec_count;  // Completed instructions
    logic [15:0]  err_count;   // Refused instructions
    logic [15:0]  rdata;       // Register read data
  } plcwx_regs_t;

  plcwx_regs_t s_q;            // Registered state
  plcwx_regs_t s_d;            // Next state
  logic        rst_meta_q;     // Reset synchroniser first stage
  logic        rst_n_q;        // Synchronised reset, active low
  logic        dec_last;       // Last digit of a decode
  logic [3:0]  dec_digit;      // Digit currently decoded
  logic [11:0] rd_lo;          // Low three digits of read data
  logic [11:0] rd_hi;          // High three digits of read data

  // Area and channel to memory address
  function automatic logic [12:0] chan_addr(input logic [2:0] area, input logic [9:0] num);
    return {area, num};
  endfunction

  // Low three BCD digits of a word to binary
  function automatic logic [13:0] bcd2bin(input logic [15:0] v);
    return 14'(v[11:8]) * 14'h0064 + 14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
  endfunction

  // BCD check for an indirect word
  function automatic logic bcd_ok(input logic [15:0] v);
    logic digits_ok;
    digits_ok = (v[15:12] <= 4'h9) && (v[11:8] <= 4'h9) && (v[7:4] <= 4'h9)
                && (v[3:0] <= 4'h9);
    return digits_ok && (v[15:12] == 4'h0) && (bcd2bin(v) < IND_LIMIT);
  endfunction

  // Channel number inside its area for this instruction
  function automatic logic in_range(input logic [2:0] area, input logic [9:0] num,
                                    input plcwx_op_t op, input logic src);
    logic       ok;
    logic [9:0] lim;
    ok  = 1'b1;
    lim = IO_MAX;
    case (area)
      AREA_IO: begin
        lim = (op == FOUR_TO_SIXTEEN_DECODE_OP && src) ? IO_SRC_MAX : IO_MAX;
      end
      AREA_LINK:        lim = LINK_MAX;
      AREA_HOLDING:     lim = HOLDING_MAX;
      AREA_TIMER_COUNTER: begin
        // Not allowed for shifts or as decode destination
        lim = TIMER_COUNTER_MAX;
        ok  = (op == CHANNEL_EXCHANGE_OP) || (op == FOUR_TO_SIXTEEN_DECODE_OP && src);
      end
      AREA_DATA_MEMORY: lim = DATA_MEMORY_MAX;
      default:          ok  = 1'b0;
    endcase
    return ok && (num <= lim);
  endfunction

  // Operand validation after indirect resolution
  function automatic logic check_fail(input plcwx_regs_t s);
    logic       bad;
    logic [9:0] last;
    bad = !in_range(s.a_area, s.a_num, s.op, 1'b1);
    case (s.op)
      CHANNEL_EXCHANGE_OP: begin
        bad = bad || !in_range(s.b_area, s.b_num, s.op, 1'b1);
      end
      DIGIT_SHIFT_LEFT_OP, DIGIT_SHIFT_RIGHT_OP: begin
        bad = bad || !in_range(s.b_area, s.b_num, s.op, 1'b1)
              || (s.a_area != s.b_area) || (s.a_num > s.b_num);
      end
      default: begin
        // Designation must hold digit 0-3 and count 0-3 only
        last = s.b_num + 10'(s.k[7:4]);
        bad  = bad || (s.k[15:8] != 8'h00) || (s.k[3:0] > DESIG_FIELD_MAX)
               || (s.k[7:4] > DESIG_FIELD_MAX) || !in_range(s.b_area, last, s.op, 1'b0);
      end
    endcase
    return bad;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Decode helpers
  assign dec_last  = (s_q.cur[1:0] == s_q.k[5:4]);
  assign dec_digit = 4'(s_q.tmp >> {s_q.k[1:0] + s_q.cur[1:0], 2'b00});
  assign rd_lo     = mem_rdata_i[11:0];
  assign rd_hi     = mem_rdata_i[15:4];

  // Next state: register port then sequencer
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.err    = 1'b0;
    s_d.mem_rd = 1'b0;
    s_d.mem_wr = 1'b0;
    s_d.rdata  = 16'h0000;
    // Register reads, unmapped offsets none
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:       s_d.rdata[CTRL_EN_BIT] = s_q.en;
        REG_STATUS: begin
          s_d.rdata[STAT_ERR_BIT]  = s_q.err_sticky;
          s_d.rdata[STAT_BUSY_BIT] = s_q.busy;
        end
        REG_EXEC_COUNT: s_d.rdata = s_q.exec_count;
        default:        s_d.rdata = s_q.err_count;
      endcase
    end
    // Register writes; status error bit clears on one
    if (reg_wr_i) begin
      if (reg_addr_i == REG_CTRL) begin
        s_d.en = reg_wdata_i[CTRL_EN_BIT];
      end else if (reg_addr_i == REG_STATUS && reg_wdata_i[STAT_ERR_BIT]) begin
        s_d.err_sticky = 1'b0;
      end
    end
    case (s_q.st)
      ST_IDLE: begin
        if (start_i) begin
          if (!cond_i || !s_q.en) begin
            s_d.done = 1'b1;
          end else begin
            s_d.op     = plcwx_op_t'(opcode_i);
            s_d.a_area = a_area_i;
            s_d.a_num  = a_num_i;
            s_d.a_ind  = a_ind_i;
            s_d.b_area = b_area_i;
            s_d.b_num  = b_num_i;
            s_d.b_ind  = b_ind_i;
            s_d.k      = k_i;
            s_d.fail   = 1'b0;
            s_d.busy   = 1'b1;
            s_d.st     = ST_IND_A;
          end
        end
      end
      ST_IND_A: begin
        s_d.st = ST_IND_B;
        if (s_q.a_ind) begin
          if (s_q.a_area != AREA_DATA_MEMORY || s_q.a_num > DATA_MEMORY_MAX) begin
            s_d.fail = 1'b1;
            s_d.st   = ST_FIN;
          end else begin
            s_d.mem_rd   = 1'b1;
            s_d.mem_addr = chan_addr(AREA_DATA_MEMORY, s_q.a_num);
            s_d.ret      = ST_GOT_A;
            s_d.st       = ST_WAIT;
          end
        end
      end
      ST_IND_B: begin
        s_d.st = ST_CHECK;
        if (s_q.b_ind) begin
          // second operand resolved from data memory
          if (s_q.b_area != AREA_DATA_MEMORY || s_q.b_num > DATA_MEMORY_MAX) begin
            s_d.fail = 1'b1;
            s_d.st   = ST_FIN;
          end else begin
            s_d.mem_rd   = 1'b1;
            s_d.mem_addr = chan_addr(AREA_DATA_MEMORY, s_q.b_num);
            s_d.ret      = ST_GOT_B;
            s_d.st       = ST_WAIT;
          end
        end
      end
      ST_GOT_A, ST_GOT_B: begin
        // pointer must be BCD below 512
        if (!bcd_ok(mem_rdata_i)) begin
          s_d.fail = 1'b1;
          s_d.st   = ST_FIN;
        end else if (s_q.st == ST_GOT_A) begin
          s_d.a_area = AREA_DATA_MEMORY;
          s_d.a_num  = 10'(bcd2bin(mem_rdata_i));
          s_d.st     = ST_IND_B;
        end else begin
          s_d.b_area = AREA_DATA_MEMORY;
          s_d.b_num  = 10'(bcd2bin(mem_rdata_i));
          s_d.st     = ST_CHECK;
        end
      end
      ST_CHECK: begin
        s_d.carry = 4'h0;
        s_d.cur   = 10'h000;
        s_d.st    = ST_RD;
        if (check_fail(s_q)) begin
          s_d.fail = 1'b1;
          s_d.st   = ST_FIN;
        end else if (s_q.op == DIGIT_SHIFT_LEFT_OP) begin
          s_d.cur = s_q.a_num;
        end else if (s_q.op == DIGIT_SHIFT_RIGHT_OP) begin
          s_d.cur = s_q.b_num;
        end
      end
      ST_RD: begin
        s_d.mem_rd = 1'b1;
        s_d.ret    = ST_EXE;
        s_d.st     = ST_WAIT;
        case (s_q.op)
          CHANNEL_EXCHANGE_OP: begin
            s_d.mem_addr = s_q.cur[0] ? chan_addr(s_q.b_area, s_q.b_num)
                                      : chan_addr(s_q.a_area, s_q.a_num);
          end
          FOUR_TO_SIXTEEN_DECODE_OP: s_d.mem_addr = chan_addr(s_q.a_area, s_q.a_num);
          default:                   s_d.mem_addr = chan_addr(s_q.a_area, s_q.cur);
        endcase
      end
      ST_WAIT: s_d.st = s_q.ret;
      ST_EXE: begin
        case (s_q.op)
          CHANNEL_EXCHANGE_OP: begin
            if (!s_q.cur[0]) begin
              s_d.tmp = mem_rdata_i;
              s_d.cur = 10'h001;
              s_d.st  = ST_RD;
            end else begin
              s_d.mem_wr    = 1'b1;
              s_d.mem_addr  = chan_addr(s_q.a_area, s_q.a_num);
              s_d.mem_wdata = mem_rdata_i;
              s_d.st        = ST_WR2;
            end
          end
          DIGIT_SHIFT_LEFT_OP: begin
            s_d.mem_wr    = 1'b1;
            s_d.mem_addr  = chan_addr(s_q.a_area, s_q.cur);
            s_d.mem_wdata = {rd_lo, s_q.carry};
            s_d.carry     = mem_rdata_i[15:12];
            s_d.cur       = s_q.cur + 10'h001;
            s_d.st        = (s_q.cur == s_q.b_num) ? ST_FIN : ST_RD;
          end
          DIGIT_SHIFT_RIGHT_OP: begin
            s_d.mem_wr    = 1'b1;
            s_d.mem_addr  = chan_addr(s_q.a_area, s_q.cur);
            s_d.mem_wdata = {s_q.carry, rd_hi};
            s_d.carry     = mem_rdata_i[3:0];
            s_d.cur       = s_q.cur - 10'h001;
            s_d.st        = (s_q.cur == s_q.a_num) ? ST_FIN : ST_RD;
          end
          default: begin
            s_d.tmp = mem_rdata_i;
            s_d.st  = ST_DEC;
          end
        endcase
      end
      ST_DEC: begin
        s_d.mem_wr    = 1'b1;
        s_d.mem_wdata = 16'h0001 << dec_digit;
        s_d.mem_addr  = chan_addr(s_q.b_area, s_q.b_num + s_q.cur);
        s_d.cur       = s_q.cur + 10'h001;
        s_d.st        = dec_last ? ST_FIN : ST_DEC;
      end
      ST_WR2: begin
        s_d.mem_wr    = 1'b1;
        s_d.mem_addr  = chan_addr(s_q.b_area, s_q.b_num);
        s_d.mem_wdata = s_q.tmp;
        s_d.st        = ST_FIN;
      end
      ST_FIN: begin
        // Error set wins over a same-cycle clear
        s_d.done = 1'b1;
        s_d.err  = s_q.fail;
        s_d.busy = 1'b0;
        s_d.st   = ST_IDLE;
        if (s_q.fail) begin
          s_d.err_sticky = 1'b1;
          s_d.err_count  = s_q.err_count + 16'h0001;
        end else begin
          s_d.exec_count = s_q.exec_count + 16'h0001;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q    <= '0;
      s_q.en <= CTRL_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign busy_o      = s_q.busy;
  assign done_o      = s_q.done;
  assign err_flag_o  = s_q.err;
  assign mem_rd_o    = s_q.mem_rd;
  assign mem_wr_o    = s_q.mem_wr;
  assign mem_addr_o  = s_q.mem_addr;
  assign mem_wdata_o = s_q.mem_wdata;
  assign reg_rdata_o = s_q.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  // Exchange write steps
  sequence xchg_wr_a_s;
    mem_wr_o && mem_addr_o == chan_addr(s_q.a_area, s_q.a_num);
  endsequence
  sequence xchg_wr_b_s;
    mem_wr_o && mem_addr_o == chan_addr(s_q.b_area, s_q.b_num) && mem_wdata_o == s_q.tmp;
  endsequence

  cond_zero_a: assert property (s_q.st == ST_IDLE && start_i && !cond_i
    |=> done_o && !busy_o && !err_flag_o ##1 !mem_wr_o && !mem_rd_o)
    else $error("condition zero did not finish idle");
  scan_exec_a: assert property (s_q.st == ST_IDLE && start_i && cond_i && s_q.en
    |=> busy_o && !done_o)
    else $error("set condition did not start execution");
  xchg_swap_a: assert property (s_q.st == ST_EXE && s_q.op == CHANNEL_EXCHANGE_OP
    && s_q.cur[0] |=> xchg_wr_a_s ##1 xchg_wr_b_s ##1 done_o)
    else $error("exchange write order wrong");
  ind_area_a: assert property (s_q.st == ST_IND_A && s_q.a_ind
    && s_q.a_area != AREA_DATA_MEMORY |=> ##1 done_o && err_flag_o)
    else $error("indirect outside data memory accepted");
  ind_bcd_a: assert property ((s_q.st == ST_GOT_A || s_q.st == ST_GOT_B)
    && !bcd_ok(mem_rdata_i) |=> s_q.st == ST_FIN ##1 err_flag_o && !mem_wr_o)
    else $error("bad indirect word accepted");
  range_err_a: assert property (s_q.st == ST_CHECK && check_fail(s_q)
    |=> !mem_rd_o ##1 done_o && err_flag_o && !mem_wr_o)
    else $error("range error not raised");
  shl_zero_a: assert property (s_q.st == ST_EXE && s_q.op == DIGIT_SHIFT_LEFT_OP
    |=> mem_wr_o && mem_wdata_o[15:4] == $past(rd_lo)
    && (mem_wdata_o[3:0] == 4'h0 || $past(s_q.cur) != $past(s_q.a_num)))
    else $error("left shift data wrong");
  shl_ascend_a: assert property (s_q.st == ST_EXE && s_q.op == DIGIT_SHIFT_LEFT_OP
    && s_q.cur != s_q.b_num |=> ##1 mem_rd_o && mem_addr_o[9:0] == $past(s_q.cur, 2) + 10'h001)
    else $error("left shift not ascending");
  shr_data_a: assert property (s_q.st == ST_EXE && s_q.op == DIGIT_SHIFT_RIGHT_OP
    |=> mem_wr_o && mem_wdata_o[11:0] == $past(rd_hi))
    else $error("right shift data wrong");
  shr_descend_a: assert property (s_q.st == ST_EXE && s_q.op == DIGIT_SHIFT_RIGHT_OP
    && s_q.cur != s_q.a_num |=> ##1 mem_rd_o && mem_addr_o[9:0] == $past(s_q.cur, 2) - 10'h001)
    else $error("right shift not descending");
  shr_fill_a: assert property (s_q.st == ST_EXE && s_q.op == DIGIT_SHIFT_RIGHT_OP
    && s_q.cur == s_q.b_num |=> mem_wdata_o[15:12] == 4'h0)
    else $error("right shift top digit not zero");
  shift_order_a: assert property (s_q.st == ST_CHECK && s_q.op != CHANNEL_EXCHANGE_OP
    && s_q.op != FOUR_TO_SIXTEEN_DECODE_OP && s_q.a_num > s_q.b_num |=> ##1 err_flag_o)
    else $error("reversed shift range accepted");
  dec_onehot_a: assert property (s_q.st == ST_DEC
    |=> mem_wr_o && $onehot(mem_wdata_o))
    else $error("decode result not one-hot");
  dec_count_a: assert property (s_q.st == ST_DEC
    |=> (s_q.st == ST_FIN) == $past(dec_last))
    else $error("decode digit count wrong");
  dec_next_a: assert property (s_q.st == ST_DEC && $past(s_q.st) == ST_DEC
    |=> mem_addr_o == $past(mem_addr_o) + 13'h0001)
    else $error("decode destination not consecutive");
  dec_digit_a: assert property (s_q.st == ST_DEC
    |=> mem_wdata_o == 16'h0001 << $past(dec_digit))
    else $error("decode digit selection wrong");

endmodule

// file: sim/plcwx_mem.sv
// Behavioural relay and data memory behind the datapath
`timescale 1ns/1ps
module plcwx_mem (
  input  wire logic        clk_i,                       // Scan clock
  input  wire logic        mem_rd_i,                    // Read strobe
  input  wire logic        mem_wr_i,                    // Write strobe
  input  wire logic [12:0] mem_addr_i,                  // Area and channel
  input  wire logic [15:0] mem_wdata_i,                 // Write data
  output logic      [15:0] mem_rdata_o = 16'h5A5A       // Read data, cycle after strobe
);
  logic [15:0] mem [0:8191];  // Whole address space
  // Write in strobe cycle; data only in the cycle after a read, else toggling junk
  always @(posedge clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
  end
endmodule

// file: sim/plc_word_exchange_shift_decode_bench.sv
// Self-checking bench for the exchange, digit shift and decode datapath
`timescale 1ns/1ps
module plc_word_exchange_shift_decode_bench;
  import plcwx_pkg::*;
  localparam logic [12:0] DMB = 13'h1000;  // Data memory base
  logic        clk = 0, resetn = 0, st = 0, cnd = 0, ai = 0, bi = 0, rw = 0, rr = 0, ef;
  logic [1:0]  op = 0, radr = 0, so;
  logic [2:0]  aa = 0, ba = 0;
  logic [9:0]  an = 0, bn = 0;
  logic [15:0] k = 0, rwd = 0, rdat, rdo, mwd, va, vb, s, w [3];
  logic [12:0] madr;
  logic        busy, done, errf, mrd, mwr;
  int          seed = 32'hc080, num_errors = 0, n_checks = 0, cyc = 0, sd;
  always #25 clk = ~clk;  // 20 MHz
  plcwx_core u_dut (.clk_i(clk), .resetn_i(resetn), .start_i(st), .cond_i(cnd),
    .opcode_i(op), .a_area_i(aa), .a_num_i(an), .a_ind_i(ai), .b_area_i(ba),
    .b_num_i(bn), .b_ind_i(bi), .k_i(k), .mem_rdata_i(rdat), .reg_addr_i(radr),
    .reg_wdata_i(rwd), .reg_wr_i(rw), .reg_rd_i(rr), .busy_o(busy), .done_o(done),
    .err_flag_o(errf), .mem_rd_o(mrd), .mem_wr_o(mwr), .mem_addr_o(madr),
    .mem_wdata_o(mwd), .reg_rdata_o(rdo));
  plcwx_mem u_mem (.clk_i(clk), .mem_rd_i(mrd), .mem_wr_i(mwr), .mem_addr_i(madr),
    .mem_wdata_i(mwd), .mem_rdata_o(rdat));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One instruction: start pulse, then wait for done under a bound
  task automatic run(input logic [1:0] o, input logic [12:0] a, input logic a_i,
                     input logic [12:0] b, input logic b_i, input logic [15:0] kk,
                     input logic c);
    int t;
    @(posedge clk);
    {st, cnd, op, aa, an, ai, ba, bn, bi, k} <= {1'b1, c, o, a, a_i, b, b_i, kk};
    @(posedge clk);
    st <= 1'b0;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (done !== 1'b1 && t < 400);
    chk({14'h0, busy, done}, 16'h0001);
    ef = errf;
  endtask
  // One register access; read data sampled in the following cycle
  task automatic reg_io(input logic wr, input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    {rw, rr, radr, rwd} <= {wr, ~wr, a, d};
    @(posedge clk);
    {rw, rr} <= 2'b00;
    @(negedge clk);
  endtask
  // Expected shifted word from neighbouring start values
  function automatic logic [15:0] exp_sh(input int d, input int i);
    if (d == 0) begin
      return {w[i][11:0], i == 0 ? 4'h0 : w[i - 1][15:12]};
    end
    return {i == 2 ? 4'h0 : w[i + 1][3:0], w[i][15:4]};
  endfunction
  // Cycle ceiling against a hung handshake
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    va = 16'($random(seed));
    vb = 16'($random(seed));
    u_mem.mem[5] = va;
    u_mem.mem[DMB + 10] = vb;
    run(CHANNEL_EXCHANGE_OP, 13'h005, 0, DMB + 10, 0, 16'($random(seed)), 1);
    chk(u_mem.mem[5], vb);
    chk(u_mem.mem[DMB + 10], va);
    run(CHANNEL_EXCHANGE_OP, 13'h005, 0, DMB + 10, 0, 16'h0, 0);
    chk(u_mem.mem[5], vb);
    run(CHANNEL_EXCHANGE_OP, 13'h005, 0, DMB + 10, 0, 16'h0, 1);
    chk(u_mem.mem[5], va);
    run(CHANNEL_EXCHANGE_OP, 13'd61, 0, DMB + 10, 0, 16'h0, 1);
    chk({15'h0, ef}, 16'h1);
    reg_io(0, REG_STATUS, 16'h0);
    chk(rdo, 16'(1 << STAT_ERR_BIT));
    reg_io(1, REG_STATUS, 16'(1 << STAT_ERR_BIT));
    reg_io(0, REG_STATUS, 16'h0);
    chk(rdo, 16'h0000);
    reg_io(1, REG_CTRL, 16'h0000);
    run(CHANNEL_EXCHANGE_OP, 13'h005, 0, DMB + 10, 0, 16'h0, 1);
    chk(u_mem.mem[5], va);
    reg_io(1, REG_CTRL, 16'(1 << CTRL_EN_BIT));
    $display("test exchange done");
    u_mem.mem[DMB + 3] = 16'h0010;
    run(CHANNEL_EXCHANGE_OP, DMB + 3, 1, 13'h005, 0, 16'h0, 1);
    chk(u_mem.mem[DMB + 10], va);
    for (int i = 0; i < 3; i++) begin
      u_mem.mem[DMB + 3] = i == 0 ? 16'h0512 : 16'h001A;
      run(CHANNEL_EXCHANGE_OP, i == 2 ? 13'h003 : DMB + 3, 1, 13'h005, 0, 16'h0, 1);
      chk({15'h0, ef}, 16'h1);
      chk(u_mem.mem[5], vb);
    end
    $display("test indirect done");
    for (int d = 0; d < 2; d++) begin
      so = d ? DIGIT_SHIFT_RIGHT_OP : DIGIT_SHIFT_LEFT_OP;
      for (int i = 0; i < 3; i++) begin
        w[i] = 16'($random(seed));
        u_mem.mem[DMB + 20 + i] = w[i];
      end
      run(so, DMB + 22, 0, DMB + 20, 0, 16'h0, 1);
      chk({15'h0, ef}, 16'h1);
      run(so, DMB + 20, 0, 13'h0815, 0, 16'h0, 1);
      chk({15'h0, ef}, 16'h1);
      chk(u_mem.mem[DMB + 20], w[0]);
      run(so, 13'h003, 1, DMB + 22, 0, 16'h0, 1);
      chk({15'h0, ef}, 16'h1);
      run(so, DMB + 20, 0, DMB + 22, 0, 16'($random(seed)), 1);
      for (int i = 0; i < 3; i++) begin
        chk(u_mem.mem[DMB + 20 + i], exp_sh(d, i));
      end
    end
    $display("test shift done");
    s = 16'($random(seed));
    u_mem.mem[DMB + 30] = s;
    for (int c = 0; c < 4; c++) begin
      sd = $random(seed) & 3;
      for (int i = 0; i < 4; i++) begin
        u_mem.mem[DMB + 40 + i] = 16'hFFFF;
      end
      // start digit given as the lowest one
      run(FOUR_TO_SIXTEEN_DECODE_OP, DMB + 30, 0, DMB + 40, 0, {8'h0, 4'(c), 4'(sd)}, 1);
      for (int i = 0; i < 4; i++) begin
        // one hot word per consecutive channel
        chk(u_mem.mem[DMB + 40 + i], i > c ? 16'hFFFF : 16'h1 << s[4 * ((sd + i) % 4) +: 4]);
      end
    end
    $display("test decode done");
    reg_io(0, REG_EXEC_COUNT, 16'h0);
    chk(rdo, 16'h0009);
    reg_io(0, REG_ERR_COUNT, 16'h0);
    chk(rdo, 16'h000A);
    give_verdict();
  end
endmodule
